// file: ber_error_reporter.sv
// error detection, classification and error queue of the bus command parser
`timescale 1ns/1ps
module ber_error_reporter
    import ber_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           nrst,
    input  wire logic           wbCycI,
    input  wire logic           wbStbI,
    input  wire logic           wbWeI,
    input  wire logic [7:0]     wbAdrI,
    input  wire logic [3:0]     wbSelI,
    input  wire logic [31:0]    wbDatI,
    output logic      [31:0]    wbDatO,
    output logic                wbAckO,
    input  wire ber_parse_ev_t  parseEv,
    input  wire ber_mod_cmd_t   modCmd,
    input  wire ber_level_req_t levelReq,
    input  wire ber_mod_pins_t  modPins,
    output logic                discardMsg,
    output logic                clearOutQueue,
    output logic                noExecute,
    output logic                suppressResp,
    output logic                errQueueNotEmpty,
    output logic      [15:0]    highLevelSetting,
    output logic      [15:0]    lowLevelSetting,
    output logic      [1:0]     hotNotice,
    output logic      [1:0]     disabledLed
);

    logic                  ack_r;
    logic [31:0]           rdData_r;
    logic [7:0]            esr_r;
    logic [1:0]            ctrl_r;
    logic [15:0]           limHi_r;
    logic [15:0]           limLo_r;
    logic [15:0]           high_r;
    logic [15:0]           low_r;
    logic                  limPrev_r;
    logic                  dlPrev_r;
    logic                  supp_r;
    logic                  discard_r;
    logic                  clrOq_r;
    logic                  noExec_r;
    logic [3:0]            pendDev_r;
    logic [1:0]            hotNotice_r;
    logic [1:0]            disLed_r;
    ber_mod_pins_t         pinMeta_r;
    ber_mod_pins_t         pinSync_r;
    ber_mod_pins_t         pinPrev_r;
    logic [9:0]            qMem_r [BER_QDEPTH];
    logic [4:0]            wrPtr_r;
    logic [4:0]            rdPtr_r;
    logic [4:0]            count_r;
    logic                  over_r;
    logic                  qNotEmpty_r;

    logic                  busTake;
    logic                  busRead;
    logic                  busWrite;
    logic                  popReq;
    logic                  push;
    logic                  pop;
    logic                  raise;
    logic                  raiseBus;
    logic [9:0]            code;
    logic                  discardNxt;
    logic                  clrOqNxt;
    logic                  noExecNxt;
    logic                  suppSet;
    logic [3:0]            devTake;
    logic [3:0]            devSet;
    logic [7:0]            esrSet;
    logic                  lvlConflict;
    logic                  reqClamp;
    logic                  limRise;
    logic                  limOutside;
    logic                  lvlClamp;
    logic                  modMissing;
    logic                  typeMismatch;
    logic                  deadlockNow;
    logic [31:0]           rdMux;

    // keep a value within the user limits
    function automatic logic [15:0] clampLim(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] t;
        t = (v < lo) ? lo : v;
        return (t > hi) ? hi : t;
    endfunction

    // one-cycle bus answer; effects take place on the acking edge
    assign busTake  = wbCycI & wbStbI & ~ack_r;
    assign busRead  = busTake & ~wbWeI;
    assign busWrite = busTake & wbWeI;
    assign popReq   = busRead & (wbAdrI == BER_OFS_ERRQ);

    // two-stage synchroniser for the module status pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            pinPrev_r <= '0;
        end else begin
            pinMeta_r <= modPins;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    // module checks against the synchronised status
    assign modMissing   = (modCmd.modCmd | modCmd.typeCheck) & ~pinSync_r.present[modCmd.slot];
    assign typeMismatch = modCmd.typeCheck & pinSync_r.present[modCmd.slot]
                          & (pinSync_r.modType[modCmd.slot] != modCmd.typeCode);
    assign deadlockNow  = parseEv.inputFull & parseEv.outputFull & parseEv.queryParsed & parseEv.ctlSending;

    // level conflicts and limit clamping
    always_comb begin
        lvlConflict = 1'b0;
        reqClamp    = 1'b0;
        if (levelReq.valid) begin
            lvlConflict = levelReq.isHigh ? (levelReq.value < low_r) : (levelReq.value > high_r);
            reqClamp    = ~lvlConflict & ctrl_r[BER_CTRL_LIMON]
                          & ((levelReq.value > limHi_r) | (levelReq.value < limLo_r));
        end
    end
    assign limRise    = ctrl_r[BER_CTRL_LIMON] & ~limPrev_r;
    assign limOutside = (high_r > limHi_r) | (high_r < limLo_r) | (low_r > limHi_r) | (low_r < limLo_r);
    assign lvlClamp   = reqClamp | (limRise & limOutside);

    // device events waiting for a free slot: overheat A,B then self disable A,B
    always_comb begin
        devSet = '0;
        for (int m = 0; m < 2; m++) begin
            devSet[m]     = pinSync_r.hot[m] & ~pinPrev_r.hot[m];
            devSet[m + 2] = pinSync_r.selfDis[m] & ~pinPrev_r.selfDis[m];
        end
        if (modCmd.reenable && pinSync_r.hot[modCmd.slot]) begin
            devSet[modCmd.slot] = 1'b1;
        end
    end

    // pick one error per cycle, first match wins
    always_comb begin
        raise      = 1'b1;
        raiseBus   = parseEv.fromBus;
        code       = BER_CODE_NONE;
        discardNxt = 1'b0;
        clrOqNxt   = 1'b0;
        noExecNxt  = 1'b0;
        suppSet    = 1'b0;
        devTake    = '0;
        if (parseEv.charTooLong) begin
            code       = BER_CODE_CHARLONG;
            discardNxt = 1'b1;
        end else if (parseEv.strNonAscii || parseEv.strEomEarly) begin
            code       = BER_CODE_BADSTR;
            discardNxt = 1'b1;
        end else if (parseEv.strWrongType) begin
            code = BER_CODE_BADSTR;
        end else if (parseEv.blkEoiCount || parseEv.blkEoiShort || parseEv.blkWrongType) begin
            code = BER_CODE_BADBLK;
        end else if (parseEv.blkBadFormat) begin
            code       = BER_CODE_BADBLKHDR;
            discardNxt = 1'b1;
        end else if (parseEv.blkBadCountChar) begin
            code = BER_CODE_BADCOUNT;
        end else if (parseEv.dataTooLong) begin
            code       = BER_CODE_TOOMUCH;
            discardNxt = 1'b1;
        end else if (parseEv.rangeErr) begin
            code      = BER_CODE_RANGE;
            noExecNxt = 1'b1;
        end else if (lvlConflict) begin
            code     = BER_CODE_CONFLICT;
            raiseBus = levelReq.fromBus;
        end else if (lvlClamp) begin
            code     = BER_CODE_LIMITED;
            raiseBus = reqClamp ? levelReq.fromBus : 1'b1;
        end else if (modMissing) begin
            code     = BER_CODE_NOHW;
            raiseBus = 1'b1;
        end else if (typeMismatch) begin
            code     = BER_CODE_BADTYPE;
            raiseBus = 1'b1;
        end else if (parseEv.recallEmpty) begin
            code = BER_CODE_EMPTYFILE;
        end else if (parseEv.newMsg && parseEv.respPending) begin
            code     = BER_CODE_INTERRUPT;
            clrOqNxt = 1'b1;
        end else if (parseEv.readNoQuery) begin
            code     = BER_CODE_UNTERM;
            clrOqNxt = 1'b1;
        end else if (deadlockNow && !dlPrev_r) begin
            code     = BER_CODE_DEADLOCK;
            clrOqNxt = 1'b1;
            suppSet  = 1'b1;
        end else if (parseEv.queryAfterIndef) begin
            code    = BER_CODE_INDEFQ;
            suppSet = 1'b1;
        end else if (pendDev_r[1:0] != 2'h0) begin
            code       = BER_CODE_TOOHOT;
            devTake[0] = pendDev_r[0];
            devTake[1] = ~pendDev_r[0];
        end else if (pendDev_r[3:2] != 2'h0) begin
            code       = BER_CODE_AUTODIS;
            devTake[2] = pendDev_r[2];
            devTake[3] = ~pendDev_r[2];
        end else begin
            raise = 1'b0;
        end
    end

    // event status bits by code class
    always_comb begin
        esrSet = '0;
        if (raise) begin
            esrSet[BER_ESR_CMD] = (code >= BER_CMD_LO) & (code <= BER_CMD_HI);
            esrSet[BER_ESR_EXE] = (code >= BER_EXE_LO) & (code <= BER_EXE_HI);
            esrSet[BER_ESR_QRY] = (code >= BER_QRY_LO) & (code <= BER_QRY_HI);
            esrSet[BER_ESR_DDE] = (code >= BER_DDE_LO);
        end
    end

    // device event pending flags, a new event wins over its own take
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pendDev_r <= '0;
        end else begin
            pendDev_r <= (pendDev_r & ~devTake) | devSet;
        end
    end

    // queue push and pop
    assign push = raise & ctrl_r[BER_CTRL_QEN]
                  & (raiseBus | (code == BER_CODE_TOOHOT) | (code == BER_CODE_AUTODIS));
    assign pop  = popReq & (count_r != 5'h00);

    // error queue storage, one entry per index
    generate
        for (genvar i = 0; i < BER_QDEPTH; i++) begin : g_entry
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    qMem_r[i] <= BER_CODE_NONE;
                end else if (push && (count_r != 5'(BER_QDEPTH) || pop) && wrPtr_r == 5'(i)) begin
                    qMem_r[i] <= code;
                end
            end
        end
    endgenerate

    // queue pointers, fill count and overflow flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrPtr_r <= 5'h00;
            rdPtr_r <= 5'h00;
            count_r <= 5'h00;
            over_r  <= 1'b0;
        end else if (busWrite && wbAdrI == BER_OFS_CTRL && wbSelI[0] && wbDatI[BER_CTRL_FLUSH]) begin
            wrPtr_r <= 5'h00;
            rdPtr_r <= 5'h00;
            count_r <= 5'h00;
            over_r  <= 1'b0;
        end else begin
            if (push && (count_r != 5'(BER_QDEPTH) || pop)) begin
                wrPtr_r <= (wrPtr_r == BER_QLAST) ? 5'h00 : wrPtr_r + 5'h01;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == BER_QLAST) ? 5'h00 : rdPtr_r + 5'h01;
            end
            if (push && !pop && count_r != 5'(BER_QDEPTH)) begin
                count_r <= count_r + 5'h01;
            end else if (pop && !push) begin
                count_r <= count_r - 5'h01;
            end
            // overflow set wins over the read that reports it
            if (push && !pop && count_r == 5'(BER_QDEPTH)) begin
                over_r <= 1'b1;
            end else if (popReq && count_r == 5'h00) begin
                over_r <= 1'b0;
            end
        end
    end

    // standard event status, cleared by a read, set wins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            esr_r <= 8'h00;
        end else if (busRead && wbAdrI == BER_OFS_ESR) begin
            esr_r <= esrSet;
        end else begin
            esr_r <= esr_r | esrSet;
        end
    end

    // response suppression until the end of the message, set wins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            supp_r <= 1'b0;
        end else if (suppSet) begin
            supp_r <= 1'b1;
        end else if (parseEv.msgEnd) begin
            supp_r <= 1'b0;
        end
    end

    // action pulses toward the parser and output queue
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            discard_r <= 1'b0;
            clrOq_r   <= 1'b0;
            noExec_r  <= 1'b0;
            dlPrev_r  <= 1'b0;
        end else begin
            discard_r <= discardNxt;
            clrOq_r   <= clrOqNxt;
            noExec_r  <= noExecNxt | lvlConflict;
            dlPrev_r  <= deadlockNow;
        end
    end

    // module indicators follow the synchronised pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hotNotice_r <= 2'h0;
            disLed_r    <= 2'h0;
        end else begin
            hotNotice_r <= pinSync_r.hot;
            disLed_r    <= pinSync_r.selfDis;
        end
    end

    // control and limit registers, byte lanes honoured
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r    <= BER_CTRL_RST;
            limHi_r   <= BER_LIMHI_RST;
            limLo_r   <= BER_LIMLO_RST;
            limPrev_r <= 1'b0;
        end else begin
            limPrev_r <= ctrl_r[BER_CTRL_LIMON];
            if (busWrite && wbAdrI == BER_OFS_CTRL && wbSelI[0]) begin
                ctrl_r <= wbDatI[1:0];
            end
            for (int b = 0; b < 2; b++) begin
                if (busWrite && wbAdrI == BER_OFS_LIMHI && wbSelI[b]) begin
                    limHi_r[b*8 +: 8] <= wbDatI[b*8 +: 8];
                end
                if (busWrite && wbAdrI == BER_OFS_LIMLO && wbSelI[b]) begin
                    limLo_r[b*8 +: 8] <= wbDatI[b*8 +: 8];
                end
            end
        end
    end

    // output level settings, clamped when limits are on
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            high_r <= BER_HIGH_RST;
            low_r  <= BER_LOW_RST;
        end else if (levelReq.valid && !lvlConflict) begin
            if (levelReq.isHigh) begin
                high_r <= reqClamp ? clampLim(levelReq.value, limLo_r, limHi_r) : levelReq.value;
            end else begin
                low_r <= reqClamp ? clampLim(levelReq.value, limLo_r, limHi_r) : levelReq.value;
            end
        end else if (limRise && limOutside) begin
            high_r <= clampLim(high_r, limLo_r, limHi_r);
            low_r  <= clampLim(low_r, limLo_r, limHi_r);
        end
    end

    // read data selection; the queue read reports overflow only once empty
    always_comb begin
        rdMux = 32'h0000_0000;
        case (wbAdrI)
            BER_OFS_ERRQ: begin
                if (count_r != 5'h00) begin
                    rdMux[9:0] = qMem_r[rdPtr_r];
                end else if (over_r) begin
                    rdMux[9:0] = BER_CODE_OVERFLOW;
                end else begin
                    rdMux[9:0] = BER_CODE_NONE;
                end
            end
            BER_OFS_ESR:    rdMux[7:0]  = esr_r;
            BER_OFS_STAT:   rdMux[10:0] = {supp_r, (count_r != 5'h00), over_r, 3'h0, count_r};
            BER_OFS_CTRL:   rdMux[1:0]  = ctrl_r;
            BER_OFS_LIMHI:  rdMux[15:0] = limHi_r;
            BER_OFS_LIMLO:  rdMux[15:0] = limLo_r;
            BER_OFS_LEVELS: rdMux       = {high_r, low_r};
            default:        rdMux       = 32'h0000_0000;
        endcase
    end

    // queue summary flag, one clock behind the fill count and overflow flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            qNotEmpty_r <= 1'b0;
        end else begin
            qNotEmpty_r <= (count_r != 5'h00) | over_r;
        end
    end

    // wishbone answer registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_r    <= 1'b0;
            rdData_r <= 32'h0000_0000;
        end else begin
            ack_r <= busTake;
            if (busRead) begin
                rdData_r <= rdMux;
            end
        end
    end

    assign wbAckO           = ack_r;
    assign wbDatO           = rdData_r;
    assign discardMsg       = discard_r;
    assign clearOutQueue    = clrOq_r;
    assign noExecute        = noExec_r;
    assign suppressResp     = supp_r;
    assign errQueueNotEmpty = qNotEmpty_r;
    assign highLevelSetting = high_r;
    assign lowLevelSetting  = low_r;
    assign hotNotice        = hotNotice_r;
    assign disabledLed      = disLed_r;

endmodule

// file: ber_pkg.sv
// package for the bus command error reporter: codes, register map, event carriers
package ber_pkg;

    // error codes reported through the error queue
    localparam logic [9:0] BER_CODE_NONE      = 10'h000; // 0
    localparam logic [9:0] BER_CODE_CHARLONG  = 10'h090; // 144
    localparam logic [9:0] BER_CODE_BADSTR    = 10'h097; // 151
    localparam logic [9:0] BER_CODE_BADBLK    = 10'h0A1; // 161
    localparam logic [9:0] BER_CODE_BADBLKHDR = 10'h0A2; // 162
    localparam logic [9:0] BER_CODE_BADCOUNT  = 10'h0A3; // 163
    localparam logic [9:0] BER_CODE_CONFLICT  = 10'h0DD; // 221
    localparam logic [9:0] BER_CODE_RANGE     = 10'h0DE; // 222
    localparam logic [9:0] BER_CODE_TOOMUCH   = 10'h0DF; // 223
    localparam logic [9:0] BER_CODE_NOHW      = 10'h0F1; // 241
    localparam logic [9:0] BER_CODE_OVERFLOW  = 10'h15E; // 350
    localparam logic [9:0] BER_CODE_INTERRUPT = 10'h19A; // 410
    localparam logic [9:0] BER_CODE_UNTERM    = 10'h1A4; // 420
    localparam logic [9:0] BER_CODE_DEADLOCK  = 10'h1AE; // 430
    localparam logic [9:0] BER_CODE_INDEFQ    = 10'h1B8; // 440
    localparam logic [9:0] BER_CODE_EMPTYFILE = 10'h1F7; // 503
    localparam logic [9:0] BER_CODE_BADTYPE   = 10'h1F9; // 505
    localparam logic [9:0] BER_CODE_LIMITED   = 10'h1FB; // 507
    localparam logic [9:0] BER_CODE_TOOHOT    = 10'h1FC; // 508
    localparam logic [9:0] BER_CODE_AUTODIS   = 10'h1FD; // 509

    // class bounds of the event status bits
    localparam logic [9:0] BER_CMD_LO = 10'h064; // 100
    localparam logic [9:0] BER_CMD_HI = 10'h0C7; // 199
    localparam logic [9:0] BER_EXE_LO = 10'h0C8; // 200
    localparam logic [9:0] BER_EXE_HI = 10'h12B; // 299
    localparam logic [9:0] BER_QRY_LO = 10'h190; // 400
    localparam logic [9:0] BER_QRY_HI = 10'h1F3; // 499
    localparam logic [9:0] BER_DDE_LO = 10'h1F4; // 500

    // standard event status bit positions
    localparam int BER_ESR_CMD = 5;
    localparam int BER_ESR_EXE = 4;
    localparam int BER_ESR_DDE = 3;
    localparam int BER_ESR_QRY = 2;

    // error queue
    localparam int         BER_QDEPTH = 31;
    localparam logic [4:0] BER_QLAST  = 5'h1E;

    // register byte offsets
    localparam logic [7:0] BER_OFS_ERRQ   = 8'h00;
    localparam logic [7:0] BER_OFS_ESR    = 8'h04;
    localparam logic [7:0] BER_OFS_STAT   = 8'h08;
    localparam logic [7:0] BER_OFS_CTRL   = 8'h0C;
    localparam logic [7:0] BER_OFS_LIMHI  = 8'h10;
    localparam logic [7:0] BER_OFS_LIMLO  = 8'h14;
    localparam logic [7:0] BER_OFS_LEVELS = 8'h18;

    // control fields and reset values
    localparam int          BER_CTRL_QEN   = 0;
    localparam int          BER_CTRL_LIMON = 1;
    localparam int          BER_CTRL_FLUSH = 2;
    localparam logic [1:0]  BER_CTRL_RST   = 2'h1;
    localparam logic [15:0] BER_LIMHI_RST  = 16'hFFFF;
    localparam logic [15:0] BER_LIMLO_RST  = 16'h0000;
    localparam logic [15:0] BER_HIGH_RST   = 16'h0000;
    localparam logic [15:0] BER_LOW_RST    = 16'h0000;

    // parser condition strobes, one cycle each unless noted
    typedef struct packed {
        logic fromBus;          // level: current message came over the bus
        logic charTooLong;
        logic strNonAscii;
        logic strEomEarly;
        logic strWrongType;
        logic blkEoiCount;
        logic blkEoiShort;
        logic blkWrongType;
        logic blkBadFormat;
        logic blkBadCountChar;
        logic dataTooLong;
        logic rangeErr;
        logic recallEmpty;
        logic newMsg;
        logic respPending;      // level
        logic readNoQuery;
        logic queryAfterIndef;
        logic inputFull;        // level
        logic outputFull;       // level
        logic queryParsed;      // level
        logic ctlSending;       // level
        logic msgEnd;
    } ber_parse_ev_t;

    // module related command strobes
    typedef struct packed {
        logic       modCmd;
        logic       typeCheck;
        logic       reenable;
        logic       slot;
        logic [3:0] typeCode;
    } ber_mod_cmd_t;

    // output level setting request
    typedef struct packed {
        logic        valid;
        logic        fromBus;
        logic        isHigh;
        logic [15:0] value;
    } ber_level_req_t;

    // module status pins, asynchronous to clock
    typedef struct packed {
        logic [1:0]      present;
        logic [1:0]      hot;
        logic [1:0]      selfDis;
        logic [1:0][3:0] modType;
    } ber_mod_pins_t;

endpackage

// file: ber_gpib_ctl.sv
// far-end controller model that turns a condition index into one parser strobe
`timescale 1ns/1ps
module ber_gpib_ctl
    import ber_pkg::*;
(
    input  wire logic [4:0] cond,
    input  wire logic       go,
    input  wire logic       bus,
    output ber_parse_ev_t   ev
);
    // one strobe at a time, index 6 reads with no terminated query sent
    // index 8 is a new message while an earlier response is still going out
    assign ev = ber_parse_ev_t'({bus, 21'h0} | ({21'h0, go} << cond)
                | ({21'h0, go && cond == 5'h08} << 7));
endmodule

// file: ber_error_reporter_assertions.sv
// concurrent checks on the error reporter ports
`timescale 1ns/1ps
module ber_error_reporter_assertions
    import ber_pkg::*;
(
    input wire logic           clock,
    input wire logic           nrst,
    input wire logic           wbCycI,
    input wire logic           wbStbI,
    input wire logic           wbAckO,
    input wire ber_parse_ev_t  parseEv,
    input wire ber_level_req_t levelReq,
    input wire logic           discardMsg,
    input wire logic           clearOutQueue,
    input wire logic           noExecute,
    input wire logic           suppressResp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    chk_ack_next: assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO) else $error("ack late");
    chk_ack_pulse: assert property (wbAckO |=> !wbAckO) else $error("ack too long");
    chk_char_discard: assert property (parseEv.charTooLong |=> discardMsg) else $error("no discard");
    chk_str_discard: assert property (parseEv.strNonAscii || parseEv.strEomEarly |=> discardMsg)
        else $error("no discard");
    chk_discard_cause: assert property (discardMsg |-> $past(parseEv.charTooLong || parseEv.strNonAscii ||
        parseEv.strEomEarly || parseEv.blkBadFormat || parseEv.dataTooLong)) else $error("stray discard");
    chk_noexec_cause: assert property (noExecute |-> $past(parseEv.rangeErr || levelReq.valid))
        else $error("stray no-execute");
    chk_clear_cause: assert property (clearOutQueue |-> $past(parseEv.newMsg || parseEv.readNoQuery ||
        parseEv.inputFull)) else $error("stray clear");
    chk_suppress_cause: assert property ($rose(suppressResp) |-> $past(parseEv.queryAfterIndef ||
        parseEv.inputFull)) else $error("stray suppress");
endmodule

bind ber_error_reporter ber_error_reporter_assertions chk (.*);

// file: ber_error_reporter_bench.sv
// self-checking bench for the error reporter
`timescale 1ns/1ps
module ber_error_reporter_bench import ber_pkg::*;;
    logic clock = 0, nrst = 0, cyc = 0, stb = 0, we = 0, go = 0, bus = 0, ack, ne;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, rdat, expq[$];
    logic [4:0] cond = '0;
    logic [15:0] hv;
    logic [1:0] hot;
    ber_level_req_t lreq = '0;
    ber_mod_cmd_t mc = '0;
    ber_mod_pins_t pins = '0;
    ber_parse_ev_t ev;
    int n_mismatch = 0, n_compared = 0;
    int idx[15] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 6, 5};
    logic [9:0] code[15] = '{10'h090, 10'h097, 10'h097, 10'h097, 10'h0A1, 10'h0A1, 10'h0A1, 10'h0A2, 10'h0A3,
        10'h0DF, 10'h0DE, 10'h1F7, 10'h19A, 10'h1A4, 10'h1B8};
    ber_gpib_ctl far (.cond(cond), .go(go), .bus(bus), .ev(ev));
    ber_error_reporter uut (.clock(clock), .nrst(nrst), .wbCycI(cyc), .wbStbI(stb), .wbWeI(we), .wbAdrI(adr),
        .wbSelI(4'hF), .wbDatI(dat), .wbDatO(rdat), .wbAckO(ack), .parseEv(ev), .modCmd(mc), .levelReq(lreq),
        .modPins(pins), .discardMsg(), .clearOutQueue(), .noExecute(), .suppressResp(), .errQueueNotEmpty(ne),
        .highLevelSetting(), .lowLevelSetting(), .hotNotice(hot), .disabledLed());
    initial forever #5 clock = ~clock;
    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        expq.push_back(want);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic raise(input int c);
        @(posedge clock);
        cond <= 5'(c);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask
    task automatic level(input logic h, input logic [15:0] v);
        @(posedge clock);
        lreq <= '{valid: 1'b1, fromBus: 1'b1, isHigh: h, value: v};
        @(posedge clock);
        lreq.valid <= 1'b0;
    endtask
    // one type check strobe for module slot 1
    task automatic modCheck(input logic [3:0] t);
        @(posedge clock);
        mc <= '{modCmd: 1'b0, typeCheck: 1'b1, reenable: 1'b0, slot: 1'b1, typeCode: t};
        @(posedge clock);
        mc.typeCheck <= 1'b0;
    endtask
    function automatic logic [31:0] esrOf(input logic [9:0] c);
        if (c < BER_EXE_LO) return 32'h20;
        if (c < BER_QRY_LO) return 32'h10;
        return (c < BER_DDE_LO) ? 32'h04 : 32'h08;
    endfunction
    // answers are matched against the oldest expectation
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0) check(rdat, expq.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        test_done();
    end
    initial begin
        void'($urandom(54482));
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd(BER_OFS_CTRL, 32'h1);
        rd(8'h40, 32'h0);
        bus <= 1'b1;
        foreach (idx[i]) begin
            raise(idx[i]);
            rd(BER_OFS_ERRQ, {22'h0, code[i]});
            rd(BER_OFS_ESR, esrOf(code[i]));
        end
        bus <= 1'b0;
        raise(12);
        rd(BER_OFS_ERRQ, 32'h0);
        bus <= 1'b1;
        for (int k = 0; k < 32; k++) raise(k[0] ? 12 : 20);
        for (int k = 0; k < 31; k++) rd(BER_OFS_ERRQ, k[0] ? 32'hA3 : 32'h90);
        rd(BER_OFS_ERRQ, 32'h15E);
        rd(BER_OFS_ERRQ, 32'h0);
        raise(12);
        wb(1'b1, BER_OFS_CTRL, 32'h5);
        rd(BER_OFS_ERRQ, 32'h0);
        rd(BER_OFS_ESR, 32'h20);
        hv = 16'h8000 | (16'($urandom) & 16'h7FF0);
        level(1'b1, hv);
        level(1'b0, hv + 16'h1);
        rd(BER_OFS_LEVELS, {hv, 16'h0});
        wb(1'b1, BER_OFS_LIMHI, 32'h200);
        wb(1'b1, BER_OFS_CTRL, 32'h3);
        repeat (3) @(posedge clock);
        rd(BER_OFS_LEVELS, 32'h02000000);
        rd(BER_OFS_ERRQ, 32'hDD);
        rd(BER_OFS_ERRQ, 32'h1FB);
        modCheck(4'h3);
        rd(BER_OFS_ERRQ, 32'hF1);
        pins <= '{present: 2'b10, hot: 2'b01, selfDis: 2'b00, modType: 8'h50};
        repeat (6) @(posedge clock);
        check({30'h0, hot}, 32'h1);
        check({31'h0, ne}, 32'h1);
        rd(BER_OFS_ERRQ, 32'h1FC);
        modCheck(4'h3);
        rd(BER_OFS_ERRQ, 32'h1F9);
        rd(BER_OFS_ESR, 32'h18);
        check({31'h0, ne}, 32'h0);
        test_done();
    end
endmodule
